// [rtl/ccmod_top.sv]
// Summary of operation
// - The mode register holds compare, rise capture, fall capture, match flag, toggle, PWM and irq enables in bits 6..0; bit 7 reads zero.
// - In capture mode the pin is sampled and rising, falling or both edges capture as enabled.
// - A valid capture copies the shared counter high and low bytes into the compare high and low registers.
// - The interrupt request is high only while the event flag and the irq enable are both set.
// - With compare and match flag enabled, the flag sets when counter and compare register become equal.
// - Compare plus match flag with toggle, PWM and captures clear is the 16-bit software timer.
// - With compare and toggle enabled and PWM clear, each counter match inverts the output pin.
// - In PWM mode the pin is low while the counter low byte is below the compare low byte, else high.
// - In PWM mode the compare low byte reloads from the compare high byte when the low byte wraps to zero.
// - PWM timing comes only from the shared counter, so all modules share one PWM frequency.
`timescale 1ns/1ps
`default_nettype none
module ccmod_top
	import ccmod_pkg::*;
(
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST_N,
	// Register bus
	input wire ccmod_axi_req_type AXI_REQ,
	output ccmod_axi_rsp_type AXI_RSP,
	// Shared counter, same clock
	input wire logic [15:0] SHARED_COUNTER,
	// Module pin
	input wire logic MODULE_PIN_IN,
	output logic MODULE_PIN_OUT,
	output logic MODULE_PIN_OE_N,
	// Interrupt request
	output logic EVENT_IRQ
);

	// ****************************************
	// Reset release
	// ****************************************
	logic [1:0] rst_sync_q;
	logic rst_n;

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_q[1];

	// ****************************************
	// State
	// ****************************************
	ccmod_state_type q;
	ccmod_state_type d;
	logic [7:0] count_low;
	logic [7:0] count_high;
	logic compare_en;
	logic rise_en;
	logic fall_en;
	logic flag_en;
	logic toggle_en;
	logic pwm_en;
	logic irq_en;
	logic eq;
	logic match;
	logic stable;
	logic edge_seen;
	logic capture;
	logic wrap;
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic do_write;
	logic [DEC_W-1:0] rd_addr;

	assign count_low = SHARED_COUNTER[7:0];
	assign count_high = SHARED_COUNTER[15:8];
	assign compare_en = q.mode[COMPARE_EN_BIT];
	assign rise_en = q.mode[CAPTURE_RISE_BIT];
	assign fall_en = q.mode[CAPTURE_FALL_BIT];
	assign flag_en = q.mode[MATCH_FLAG_BIT];
	assign toggle_en = q.mode[MATCH_TOGGLE_BIT];
	assign pwm_en = q.mode[PULSE_WIDTH_BIT];
	assign irq_en = q.mode[EVENT_IRQ_BIT];

	// ****************************************
	// Bus handshakes
	// ****************************************
	assign AXI_RSP.awready = !q.aw_got && !q.bvalid;
	assign AXI_RSP.wready = !q.w_got && !q.bvalid;
	assign AXI_RSP.arready = !q.rvalid;
	assign AXI_RSP.bvalid = q.bvalid;
	assign AXI_RSP.bresp = q.bresp;
	assign AXI_RSP.rvalid = q.rvalid;
	assign AXI_RSP.rresp = q.rresp;
	assign AXI_RSP.rdata = {READ_PAD, q.rdata};

	assign aw_take = AXI_REQ.awvalid && AXI_RSP.awready;
	assign w_take = AXI_REQ.wvalid && AXI_RSP.wready;
	assign ar_take = AXI_REQ.arvalid && AXI_RSP.arready;
	assign do_write = q.aw_got && q.w_got;
	assign rd_addr = AXI_REQ.araddr[DEC_W-1:0];

	// ****************************************
	// Event detection
	// ****************************************
	// Equality edge so a held match counts once
	assign eq = SHARED_COUNTER == {q.cmp_high, q.cmp_low};
	assign match = compare_en && eq && !q.eq_q;

	// Only stages two and three are compared
	assign stable = q.pin_sync[1] == q.pin_sync[2];
	assign edge_seen = q.pin_valid && stable && (q.pin_sync[1] != q.pin_level);
	assign capture = edge_seen && ((q.pin_sync[1] && rise_en) || (!q.pin_sync[1] && fall_en));

	assign wrap = q.low_valid && (q.low_prev == LOW_MAX) && (count_low == LOW_ZERO);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		d = q;
		d.eq_q = eq;
		d.low_prev = count_low;
		d.low_valid = 1'b1;
		d.pin_sync = {q.pin_sync[1:0], MODULE_PIN_IN};
		if (stable) begin
			d.pin_level = q.pin_sync[1];
			d.pin_valid = 1'b1;
		end

		// Write address and data in either order
		if (aw_take) begin
			d.aw_got = 1'b1;
			d.awaddr = AXI_REQ.awaddr[DEC_W-1:0];
		end
		if (w_take) begin
			d.w_got = 1'b1;
			d.wdata = AXI_REQ.wdata[7:0];
			d.wlane = AXI_REQ.wstrb[STRB_LANE];
		end
		if (q.bvalid && AXI_REQ.bready) begin
			d.bvalid = 1'b0;
		end
		if (do_write) begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = RESP_OKAY;
			unique case (q.awaddr)
				MODE_OFFSET: begin
					if (q.wlane) begin
						d.mode = q.wdata & MODE_WRITE_MASK;
					end
				end
				CMP_LOW_OFFSET: begin
					if (q.wlane) begin
						d.cmp_low = q.wdata;
					end
				end
				CMP_HIGH_OFFSET: begin
					if (q.wlane) begin
						d.cmp_high = q.wdata;
					end
				end
				FLAG_OFFSET: begin
					if (q.wlane) begin
						d.flag = q.wdata[FLAG_BIT];
					end
				end
				default: begin
					d.bresp = RESP_SLVERR;
				end
			endcase
		end

		// Read answer one cycle after address
		if (q.rvalid && AXI_REQ.rready) begin
			d.rvalid = 1'b0;
		end
		if (ar_take) begin
			d.rvalid = 1'b1;
			d.rresp = RESP_OKAY;
			unique case (rd_addr)
				MODE_OFFSET: d.rdata = q.mode;
				CMP_LOW_OFFSET: d.rdata = q.cmp_low;
				CMP_HIGH_OFFSET: d.rdata = q.cmp_high;
				FLAG_OFFSET: d.rdata = {FLAG_PAD, q.flag};
				default: begin
					d.rdata = LOW_ZERO;
					d.rresp = RESP_SLVERR;
				end
			endcase
		end

		// Hardware updates override a same-cycle write
		if (capture) begin
			d.cmp_high = count_high;
			d.cmp_low = count_low;
		end
		if (compare_en && pwm_en) begin
			if (wrap) begin
				d.cmp_low = q.cmp_high;
				d.pin_out = q.cmp_high <= count_low;
			end else begin
				d.pin_out = q.cmp_low <= count_low;
			end
		end else if (match && toggle_en) begin
			d.pin_out = !q.pin_out;
		end

		// Set wins over software clear
		if ((match && flag_en) || capture) begin
			d.flag = 1'b1;
		end
	end

	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.mode <= MODE_RESET;
			q.cmp_low <= CMP_LOW_RESET;
			q.cmp_high <= CMP_HIGH_RESET;
			q.pin_sync <= SYNC_RESET;
			q.bresp <= RESP_OKAY;
			q.rresp <= RESP_OKAY;
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign MODULE_PIN_OUT = q.pin_out;
	// Pin is driven only in toggle or PWM output use
	assign MODULE_PIN_OE_N = !(compare_en && (toggle_en || pwm_en));
	assign EVENT_IRQ = q.flag && irq_en;

endmodule : ccmod_top
`default_nettype wire

// [rtl/ccmod_pkg.sv]
`default_nettype none
package ccmod_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam int DEC_W = 8;
	localparam logic [DEC_W-1:0] MODE_OFFSET = 8'h00;
	localparam logic [DEC_W-1:0] CMP_LOW_OFFSET = 8'h04;
	localparam logic [DEC_W-1:0] CMP_HIGH_OFFSET = 8'h08;
	localparam logic [DEC_W-1:0] FLAG_OFFSET = 8'h0c;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] CMP_LOW_RESET = 8'h00;
	localparam logic [7:0] CMP_HIGH_RESET = 8'h00;
	localparam logic [7:0] MODE_WRITE_MASK = 8'h7f;
	localparam logic [23:0] READ_PAD = 24'h000000;
	localparam logic [6:0] FLAG_PAD = 7'h00;

	// ****************************************
	// Mode register fields
	// ****************************************
	localparam int COMPARE_EN_BIT = 6;
	localparam int CAPTURE_RISE_BIT = 5;
	localparam int CAPTURE_FALL_BIT = 4;
	localparam int MATCH_FLAG_BIT = 3;
	localparam int MATCH_TOGGLE_BIT = 2;
	localparam int PULSE_WIDTH_BIT = 1;
	localparam int EVENT_IRQ_BIT = 0;
	localparam int FLAG_BIT = 0;
	localparam int STRB_LANE = 0;

	// ****************************************
	// Counter and bus constants
	// ****************************************
	localparam logic [7:0] LOW_MAX = 8'hff;
	localparam logic [7:0] LOW_ZERO = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [2:0] SYNC_RESET = 3'h0;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic [31:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [31:0] araddr;
		logic arvalid;
		logic rready;
	} ccmod_axi_req_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} ccmod_axi_rsp_type;

	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] cmp_low;
		logic [7:0] cmp_high;
		logic flag;
		logic pin_out;
		logic eq_q;
		logic [7:0] low_prev;
		logic low_valid;
		logic [2:0] pin_sync;
		logic pin_level;
		logic pin_valid;
		logic aw_got;
		logic [DEC_W-1:0] awaddr;
		logic w_got;
		logic [7:0] wdata;
		logic wlane;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [7:0] rdata;
	} ccmod_state_type;
endpackage : ccmod_pkg
`default_nettype wire

// [sim/ccmod_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ccmod_pin_model (
	// Far side and module drive
	input wire logic src,
	input wire logic dout,
	input wire logic oe_n,
	// Pin level
	output logic pin
);
	// Module owns the pin while enable is low
	assign pin = oe_n ? src : dout;
endmodule : ccmod_pin_model
`default_nettype wire

// [sim/ccmod_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module ccmod_monitor
	import ccmod_pkg::*;
(
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST_N,
	// Bus
	input wire ccmod_axi_req_type AXI_REQ,
	input wire ccmod_axi_rsp_type AXI_RSP,
	// Counter, pin, irq
	input wire logic [15:0] SHARED_COUNTER,
	input wire logic MODULE_PIN_IN,
	input wire logic MODULE_PIN_OUT,
	input wire logic MODULE_PIN_OE_N,
	input wire logic EVENT_IRQ
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	bhold_a: assert property (AXI_RSP.bvalid && !AXI_REQ.bready |=> AXI_RSP.bvalid && $stable(AXI_RSP.bresp))
		else $error("b held");
	rhold_a: assert property (AXI_RSP.rvalid && !AXI_REQ.rready |=> AXI_RSP.rvalid && $stable(AXI_RSP.rdata))
		else $error("r held");
	bdone_a: assert property (AXI_RSP.bvalid && AXI_REQ.bready |=> !AXI_RSP.bvalid) else $error("b done");
	rdone_a: assert property (AXI_RSP.rvalid && AXI_REQ.rready |=> !AXI_RSP.rvalid) else $error("r done");
	wbusy_a: assert property (AXI_RSP.bvalid |-> !AXI_RSP.awready && !AXI_RSP.wready) else $error("w busy");
	rbusy_a: assert property (AXI_RSP.rvalid |-> !AXI_RSP.arready) else $error("r busy");
	rpad_a: assert property (AXI_RSP.rvalid |-> AXI_RSP.rdata[31:8] == READ_PAD) else $error("r pad");
	mode_top_a: assert property (AXI_REQ.arvalid && AXI_RSP.arready && AXI_REQ.araddr[7:0] == MODE_OFFSET
		|=> !AXI_RSP.rdata[7]) else $error("mode bit seven set");
	rlat_a: assert property (AXI_REQ.arvalid && AXI_RSP.arready |=> AXI_RSP.rvalid) else $error("r late");
	wlat_a: assert property (AXI_REQ.awvalid && AXI_RSP.awready && AXI_REQ.wvalid && AXI_RSP.wready
		|=> !AXI_RSP.bvalid ##1 AXI_RSP.bvalid) else $error("w late");
	rst_out_a: assert property (disable iff (1'b0) !RST_N ##1 !RST_N
		|-> MODULE_PIN_OE_N && !EVENT_IRQ && !MODULE_PIN_OUT) else $error("reset out");
	cover property ($rose(EVENT_IRQ));
	cover property (!MODULE_PIN_OE_N && SHARED_COUNTER[7:0] == 8'hff);
	cover property ($rose(MODULE_PIN_IN));
	cover property (AXI_RSP.rvalid && AXI_RSP.rresp == RESP_SLVERR);
endmodule : ccmod_monitor
bind ccmod_top ccmod_monitor MON(.CLOCK(CLOCK), .RST_N(RST_N), .AXI_REQ(AXI_REQ), .AXI_RSP(AXI_RSP),
	.SHARED_COUNTER(SHARED_COUNTER), .MODULE_PIN_IN(MODULE_PIN_IN), .MODULE_PIN_OUT(MODULE_PIN_OUT),
	.MODULE_PIN_OE_N(MODULE_PIN_OE_N), .EVENT_IRQ(EVENT_IRQ));
`default_nettype wire

// [sim/counter_array_compare_capture_test.sv]
`timescale 1ns/1ps
`default_nettype none
module counter_array_compare_capture_test;
	import ccmod_pkg::*;
	logic CLOCK = 0, RST_N = 0, src = 0, pin, dout, oe_n, irq, p;
	logic [15:0] cnt = 0, t, c;
	logic [7:0] r = 8'h1f, lo, hi;
	logic [7:0] cm [3] = '{8'h20, 8'h10, 8'h30};
	logic [31:0] d;
	int n_mismatch = 0, tests_run = 0, cyc = 0;
	ccmod_axi_req_type rq = '0;
	ccmod_axi_rsp_type rs;
	always #5 CLOCK = ~CLOCK;
	always @(posedge CLOCK) cnt <= cnt + 16'h0001;
	ccmod_top DUT(.CLOCK(CLOCK), .RST_N(RST_N), .AXI_REQ(rq), .AXI_RSP(rs), .SHARED_COUNTER(cnt),
		.MODULE_PIN_IN(pin), .MODULE_PIN_OUT(dout), .MODULE_PIN_OE_N(oe_n), .EVENT_IRQ(irq));
	ccmod_pin_model PM(.src(src), .dout(dout), .oe_n(oe_n), .pin(pin));
	function automatic logic [7:0] nx(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : nx
	task chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			n_mismatch++;
			$display("Error %0t seen %h exp %h", $time, s, e);
		end
	endtask : chk
	task report_and_stop;
		$display("Mismatches %0d of %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : report_and_stop
	task wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] e);
		logic ga, gw;
		ga = 0;
		gw = 0;
		@(posedge CLOCK);
		rq.awaddr <= {24'h000000, a};
		rq.wdata <= {24'h000000, v};
		rq.wstrb <= 4'h1;
		rq.awvalid <= 1'b1;
		rq.wvalid <= 1'b1;
		rq.bready <= 1'b1;
		while (!(ga && gw)) begin
			@(posedge CLOCK);
			ga = ga || rs.awready === 1'b1;
			gw = gw || rs.wready === 1'b1;
			rq.awvalid <= !ga;
			rq.wvalid <= !gw;
		end
		while (rs.bvalid !== 1'b1) @(posedge CLOCK);
		chk(rs.bresp, e);
		rq.bready <= 1'b0;
	endtask : wr
	// All ones skips the data compare
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge CLOCK);
		rq.araddr <= {24'h000000, a};
		rq.arvalid <= 1'b1;
		rq.rready <= 1'b1;
		do @(posedge CLOCK); while (rs.arready !== 1'b1);
		rq.arvalid <= 1'b0;
		while (rs.rvalid !== 1'b1) @(posedge CLOCK);
		d = rs.rdata;
		chk(rs.rresp, er);
		if (e !== '1) chk(d, e);
		rq.rready <= 1'b0;
	endtask : rd
	task arm(input logic [7:0] mv);
		t = cnt + 16'd60;
		wr(CMP_LOW_OFFSET, t[7:0], RESP_OKAY);
		wr(CMP_HIGH_OFFSET, t[15:8], RESP_OKAY);
		wr(MODE_OFFSET, mv, RESP_OKAY);
		p = dout;
		while (cnt != t + 16'd4) @(posedge CLOCK);
		#1;
	endtask : arm
	always @(posedge CLOCK) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			report_and_stop;
		end
	end
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		repeat (3) @(posedge CLOCK);
		RST_N <= 1'b1;
		repeat (3) @(posedge CLOCK);
		for (int i = 0; i < 5; i++) rd(8'(4 * i), 0, i == 4 ? RESP_SLVERR : RESP_OKAY);
		wr(8'h10, 8'h55, RESP_SLVERR);
		wr(MODE_OFFSET, 8'hff, RESP_OKAY);
		rd(MODE_OFFSET, 32'h7f, RESP_OKAY);
		// Quiet the module so the timer flag below comes from the match alone
		wr(MODE_OFFSET, 8'h00, RESP_OKAY);
		wr(FLAG_OFFSET, 8'h00, RESP_OKAY);
		rd(FLAG_OFFSET, 0, RESP_OKAY);
		arm(8'h49);
		chk(irq, 1);
		chk(oe_n, 1);
		rd(FLAG_OFFSET, 1, RESP_OKAY);
		wr(MODE_OFFSET, 8'h48, RESP_OKAY);
		chk(irq, 0);
		wr(FLAG_OFFSET, 8'h00, RESP_OKAY);
		rd(FLAG_OFFSET, 0, RESP_OKAY);
		arm(8'h4c);
		chk(dout, !p);
		chk(oe_n, 0);
		while (cnt[7:0] != 8'h10) @(posedge CLOCK);
		r = nx(r);
		hi = r;
		lo = 8'h40;
		wr(CMP_LOW_OFFSET, lo, RESP_OKAY);
		wr(CMP_HIGH_OFFSET, hi, RESP_OKAY);
		wr(MODE_OFFSET, 8'h42, RESP_OKAY);
		c = cnt;
		repeat (600) begin
			@(posedge CLOCK);
			if (c[7:0] == LOW_MAX && cnt[7:0] == LOW_ZERO) lo = hi;
			c = cnt;
			#1 chk(dout, c[7:0] >= lo);
		end
		for (int k = 0; k < 3; k++) begin
			wr(MODE_OFFSET, cm[k], RESP_OKAY);
			wr(FLAG_OFFSET, 8'h00, RESP_OKAY);
			for (int b = 1; b >= 0; b--) begin
				c = cnt;
				src <= b[0];
				repeat (10) @(posedge CLOCK);
				rd(FLAG_OFFSET, b ? cm[k][5] : cm[k][4], RESP_OKAY);
				if (d[0]) begin
					rd(CMP_LOW_OFFSET, '1, RESP_OKAY);
					lo = d[7:0];
					rd(CMP_HIGH_OFFSET, '1, RESP_OKAY);
					t = {d[7:0], lo};
					chk(t - c < 16'd8, 1);
				end
				wr(FLAG_OFFSET, 8'h00, RESP_OKAY);
			end
		end
		report_and_stop;
	end
endmodule : counter_array_compare_capture_test
`default_nettype wire
